// [hdl/spi_register_command_decoder.v]
// serial command decoder with write-unlocked configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "spi_cmd_map.vh"
module spi_register_command_decoder
(
    input  wire       sys_clk_in,
    input  wire       nrst_in,
    input  wire       clk_en_in,
    input  wire       sclk_in,
    input  wire       cs_n_in,
    input  wire       sdi_in,
    output reg        sdo_out,
    output wire [7:0] power_down_control_out,
    output wire [1:0] input_mode_out,
    output wire [7:0] output_protocol_select_out,
    output wire [7:0] output_rate_select_out,
    output wire [7:0] status_pin_config_out,
    output wire [7:0] output_word_config_out,
    output wire [7:0] parity_config_out,
    output wire       write_unlocked_out
);
    // synchronised pins: [0] sclk, [1] inverted cs_n, [2] sdi
    wire [2:0] pins_sync;
    reg        sclk_d;
    reg        cs_n_d;

    // shift state
    reg [23:0] shift_reg;
    reg [4:0]  bit_count;
    reg [7:0]  read_data;
    reg        read_pending;
    reg [7:0]  out_shift;

    // configuration registers
    reg [7:0] write_unlock_key;
    reg [7:0] power_down_control;
    reg [7:0] input_protocol_select;
    reg [7:0] output_protocol_select;
    reg [7:0] output_rate_select;
    reg [7:0] output_reserved_control;
    reg [7:0] status_pin_config;
    reg [7:0] output_word_config;
    reg [7:0] parity_config;

    wire sclk_s = pins_sync[0];
    // chip select travels inverted so its idle level matches the zero reset of the flops;
    // otherwise reset would show a false frame start and end
    wire cs_n_s = ~pins_sync[1];
    wire sdi_s  = pins_sync[2];

    // frame fields
    wire [4:0]  op    = shift_reg[`OP_MSB:`OP_LSB];
    wire [10:0] addr  = shift_reg[`ADDR_MSB:`ADDR_LSB];
    wire [7:0]  data  = shift_reg[`DATA_MSB:0];

    // clock polarity and phase from the input mode field
    wire cpol = input_protocol_select[`IN_MODE_MSB];
    wire cpha = input_protocol_select[0];

    // sclk edges seen from the system clock; the leading edge leaves idle level
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire lead_edge = cpol ? sclk_fall : sclk_rise;
    wire trail_edge = cpol ? sclk_rise : sclk_fall;
    // mode 0 and 2 sample on the leading edge, 1 and 3 on the trailing edge
    wire sample_edge = cpha ? trail_edge : lead_edge;
    wire launch_edge = cpha ? lead_edge : trail_edge;

    wire frame_active = ~cs_n_s;
    wire cs_fall = ~cs_n_s & cs_n_d;
    wire cs_rise = cs_n_s & ~cs_n_d;
    wire frame_full = (bit_count == 5'd24);
    wire unlocked = (write_unlock_key == `UNLOCK_KEY);

    // first-edge launch is taken at the chip-select fall in phase 0 modes
    wire launch_now = frame_active & launch_edge & ~cs_fall;

    // pin synchroniser: sclk, cs_n and sdi pass two flops first; nrst_in and clk_en_in are used directly
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .sys_clk_in     (sys_clk_in),
        .nrst_in        (nrst_in),
        .clk_en_in      (clk_en_in),
        .async_in       ({sdi_in, ~cs_n_in, sclk_in}),
        .reset_level_in (3'h0),
        .sync_out       (pins_sync)
    );

    // edge detectors run on the second synchroniser stage only
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end
        else if (clk_en_in)
        begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // value currently held at an address; unmapped and reserved read zero
    function [7:0] reg_value;
        input [10:0] a;
        begin
            if (a == `ADDR_UNLOCK)
                reg_value = write_unlock_key;
            else if (a == `ADDR_POWER_DOWN)
                reg_value = power_down_control;
            else if (a == `ADDR_IN_PROTO)
                reg_value = input_protocol_select;
            else if (a == `ADDR_OUT_PROTO)
                reg_value = output_protocol_select;
            else if (a == `ADDR_OUT_RATE)
                reg_value = output_rate_select;
            else if (a == `ADDR_OUT_RSVD)
                reg_value = output_reserved_control;
            else if (a == `ADDR_STATUS_PIN)
                reg_value = status_pin_config;
            else if (a == `ADDR_WORD_CFG)
                reg_value = output_word_config;
            else if (a == `ADDR_PARITY)
                reg_value = parity_config;
            else
                reg_value = 8'h00;
        end
    endfunction

    // new register value for the decoded command
    reg [7:0] next_value;
    reg       do_write;
    always @*
    begin
        next_value = 8'h00;
        do_write   = 1'b0;
        if (frame_full)
        begin
            if (op == `OP_WRITE)
            begin
                next_value = data;
                do_write   = 1'b1;
            end
            else if (op == `OP_SET_BITS)
            begin
                next_value = reg_value(addr) | data;
                do_write   = 1'b1;
            end
            else if (op == `OP_CLEAR_BITS)
            begin
                next_value = reg_value(addr) & ~data;
                do_write   = 1'b1;
            end
            // nop and reserved opcodes leave do_write low
        end
    end

    wire commit = cs_rise & do_write;
    // unlock register always writable; others need the key
    wire cfg_ok = commit & unlocked;

    // serial input shift and bit counter, msb first
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            shift_reg <= 24'h000000;
            bit_count <= 5'd0;
        end
        else if (clk_en_in)
        begin
            if (cs_fall)
            begin
                shift_reg <= 24'h000000;
                bit_count <= 5'd0;
            end
            else if (frame_active && sample_edge)
            begin
                shift_reg <= {shift_reg[22:0], sdi_s};
                // extra clocks beyond 24 invalidate the frame
                bit_count <= (bit_count == 5'd31) ? bit_count : bit_count + 5'd1;
            end
        end
    end

    // registers update on the chip-select rise of a complete frame
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            write_unlock_key        <= `RESET_VALUE;
            power_down_control      <= `RESET_VALUE;
            input_protocol_select   <= `RESET_VALUE;
            output_protocol_select  <= `RESET_VALUE;
            output_rate_select      <= `RESET_VALUE;
            output_reserved_control <= `RESET_VALUE;
            status_pin_config       <= `RESET_VALUE;
            output_word_config      <= `RESET_VALUE;
            parity_config           <= `RESET_VALUE;
        end
        else if (clk_en_in)
        begin
            // address decode
            if (commit && addr == `ADDR_UNLOCK)
                write_unlock_key <= next_value & `MASK_UNLOCK;
            else if (cfg_ok && addr == `ADDR_POWER_DOWN)
                power_down_control <= next_value & `MASK_POWER_DOWN;
            else if (cfg_ok && addr == `ADDR_IN_PROTO)
                input_protocol_select <= next_value & `MASK_IN_PROTO;
            else if (cfg_ok && addr == `ADDR_OUT_PROTO)
                output_protocol_select <= next_value & `MASK_OUT_PROTO;
            else if (cfg_ok && addr == `ADDR_OUT_RATE)
                output_rate_select <= next_value & `MASK_FULL;
            else if (cfg_ok && addr == `ADDR_STATUS_PIN)
                status_pin_config <= next_value & `MASK_FULL;
            else if (cfg_ok && addr == `ADDR_WORD_CFG)
                output_word_config <= next_value & `MASK_FULL;
            else if (cfg_ok && addr == `ADDR_PARITY)
                parity_config <= next_value & `MASK_FULL;
            // 0Eh is reserved: writes dropped, reads stay zero
        end
    end

    // read command latches the addressed value for the next frame
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            read_data    <= 8'h00;
            read_pending <= 1'b0;
        end
        else if (clk_en_in && cs_rise)
        begin
            if (frame_full && op == `OP_READ)
            begin
                read_data    <= reg_value(addr);
                read_pending <= 1'b1;
            end
            else
            begin
                read_data    <= 8'h00;
                read_pending <= 1'b0;
            end
        end
    end

    // serial output: first eight bits of the following frame carry read data
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            out_shift <= 8'h00;
            sdo_out   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (cs_fall)
            begin
                // phase 0 launches the msb at the chip-select fall
                out_shift <= {read_data[6:0], 1'b0};
                sdo_out   <= cpha ? 1'b0 : read_data[7];
                if (cpha)
                    out_shift <= read_data;
            end
            else if (launch_now)
            begin
                sdo_out   <= out_shift[7];
                out_shift <= {out_shift[6:0], 1'b0};
            end
            else if (!frame_active)
                sdo_out <= 1'b0;
        end
    end

    // configuration fields driven to the converter core
    assign power_down_control_out     = power_down_control;
    assign input_mode_out             = input_protocol_select[1:0];
    assign output_protocol_select_out = output_protocol_select;
    assign output_rate_select_out     = output_rate_select;
    assign status_pin_config_out      = status_pin_config;
    assign output_word_config_out     = output_word_config;
    assign parity_config_out          = parity_config;
    assign write_unlocked_out         = unlocked;

    // read_pending drives no output and is only folded into unused_ok; output_reserved_control reaches sdo_out only through reads of 0Eh
    wire unused_ok = read_pending | (|output_reserved_control);
endmodule // spi_register_command_decoder
`default_nettype wire

// [hdl/spi_cmd_map.vh]
// register offsets, field positions, reset values and command codes of the serial decoder
// Operation
// - top five frame bits pick operation: 0 nop, 1 write, 2 read; address, data follow
// - opcode 3 sets masked bits, opcode 4 clears masked bits at the address
// - any other opcode is a no-operation: no register change, no read started
// - serial input is captured on edges of the host serial clock only
// - clear command zeroes bits whose mask is one, keeps the rest
// - set command forces to one bits whose mask is one, keeps the rest
// - register read takes two frames: command frame, then data frame
// - read decoded at chip-select rise; data ready for the very next frame
// - next frame's first eight output bits are the addressed register
// - write frame is 24 bits: opcode, 11-bit address, 8-bit value
// - write decoded at chip-select rise and register updated then
// - configuration writes allowed only while unlock key holds 1010 1010b
// - unlock register is fully read-write and resets to zero
// - registers decode at 00h, 04h, 08h, 0Ch to 11h; 0Eh reserved
// - after reset, clock polarity 0 with rising-edge sample and falling-edge launch is used
// - non-unlock registers reject writes after reset until the key is written
`ifndef SPI_CMD_MAP_VH
`define SPI_CMD_MAP_VH

`define FRAME_BITS        24
`define OP_MSB            23
`define OP_LSB            19
`define ADDR_MSB          18
`define ADDR_LSB          8
`define DATA_MSB          7

`define OP_NOP            5'h00
`define OP_WRITE          5'h01
`define OP_READ           5'h02
`define OP_SET_BITS       5'h03
`define OP_CLEAR_BITS     5'h04

`define ADDR_UNLOCK       11'h000
`define ADDR_POWER_DOWN   11'h004
`define ADDR_IN_PROTO     11'h008
`define ADDR_OUT_PROTO    11'h00c
`define ADDR_OUT_RATE     11'h00d
`define ADDR_OUT_RSVD     11'h00e
`define ADDR_STATUS_PIN   11'h00f
`define ADDR_WORD_CFG     11'h010
`define ADDR_PARITY       11'h011

`define UNLOCK_KEY        8'haa
`define RESET_VALUE       8'h00

// writable bit masks; reserved bits read as zero
`define MASK_UNLOCK       8'hff
`define MASK_POWER_DOWN   8'h1e
`define MASK_IN_PROTO     8'h03
`define MASK_OUT_PROTO    8'h77
`define MASK_FULL         8'hff

`define IN_MODE_MSB       1

`endif

// [hdl/pin_sync.v]
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
    parameter WIDTH = 3
)
(
    input  wire             sys_clk_in,
    input  wire             nrst_in,
    input  wire             clk_en_in,
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] reset_level_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    genvar i;

    // per bit: first stage feeds only the second; both stages reset to zero, reset_level_in is not used
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always @(posedge sys_clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else if (clk_en_in)
                begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// [tb/spi_cmd_checker_properties.sv]
// port-level checks for the serial command decoder
`timescale 1ns/100ps
`default_nettype none
module spi_cmd_checker
(
    input wire logic       sys_clk_in,
    input wire logic       nrst_in,
    input wire logic       sclk_in,
    input wire logic       cs_n_in,
    input wire logic       sdo_out,
    input wire logic [7:0] power_down_control_out,
    input wire logic [1:0] input_mode_out,
    input wire logic [7:0] output_protocol_select_out,
    input wire logic [7:0] output_rate_select_out,
    input wire logic [7:0] status_pin_config_out,
    input wire logic [7:0] output_word_config_out,
    input wire logic [7:0] parity_config_out,
    input wire logic       write_unlocked_out
);
    logic [3:0] quiet;
    logic       sclk_q;
    logic       cs_q;
    // every configuration output in one bundle
    wire [49:0] cfg = {power_down_control_out, input_mode_out, output_protocol_select_out,
        output_rate_select_out, status_pin_config_out, output_word_config_out,
        parity_config_out};
    // cycles since a pin edge; saturates so it never wraps back into range
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        sclk_q <= sclk_in;
        cs_q   <= cs_n_in;
        if (!nrst_in || sclk_in != sclk_q || cs_n_in != cs_q)
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence cs_idle;
        cs_n_in[*6];
    endsequence
    sequence frame_mid;
        !cs_n_in[*8];
    endsequence
    reset_zero_a: assert property ($rose(nrst_in) |-> cfg == 50'h0 && !write_unlocked_out)
        else $error("outputs not zero after reset");
    unlock_gate_a: assert property ($changed(cfg) |-> $past(write_unlocked_out))
        else $error("configuration changed while locked");
    cs_rise_a: assert property ($changed({cfg, write_unlocked_out})
        |-> $past(cs_n_in) && $past(cs_n_in, 2)) else $error("update without frame end");
    frame_hold_a: assert property (frame_mid |-> $stable({cfg, write_unlocked_out}))
        else $error("register moved inside a frame");
    sdo_idle_a: assert property (cs_idle |-> !sdo_out)
        else $error("serial output busy outside frame");
    sdo_launch_a: assert property ($changed(sdo_out) |-> quiet <= 4'd6)
        else $error("serial output moved without pin edge");
    pd_mask_a: assert property ((power_down_control_out & 8'he1) == 8'h00)
        else $error("power-down reserved bit set");
    proto_mask_a: assert property ((output_protocol_select_out & 8'h88) == 8'h00)
        else $error("protocol reserved bit set");
endmodule // spi_cmd_checker
`default_nettype wire

// [tb/spi_host_model.sv]
// host serial master issuing command frames in clock mode 00
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
(
    output var logic sclk_out,
    output var logic cs_n_out,
    output var logic sdi_out,
    input wire logic sdo_in
);
    // idle bus: clock low, deselected
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b1;
    end
    // n bits msb first, zeros past bit 0; clock stands low between frames
    task automatic frame(input logic [23:0] cmd, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        cs_n_out = 1'b0;
        for (int i = 23; i > 23 - n; i--)
        begin
            sdi_out = (i >= 0) ? cmd[i] : 1'b0;
            #62.5 sclk_out = 1'b1;
            rd = {rd[22:0], sdo_in};
            #62.5 sclk_out = 1'b0;
        end
        #62.5 cs_n_out = 1'b1; // 24 clocks make a valid frame
        sdi_out = ~sdi_out; // released line must not keep the last bit
        #250;
    endtask
endmodule // spi_host_model
`default_nettype wire

// [tb/test_spi_register_command_decoder.sv]
// self-checking bench for the serial command decoder
`timescale 1ns/100ps
`default_nettype none
`include "spi_cmd_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module test_spi_register_command_decoder;
    logic        sys_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    wire         sclk, cs_n, sdi, sdo, unl;
    wire  [7:0]  pd, proto, rate, stat, word, par;
    wire  [1:0]  mode;
    logic [23:0] rd;
    int          error_cnt = 0;
    int          checks_done = 0;
    logic [10:0] at [8] = '{11'h004, 11'h00c, 11'h00d, 11'h00f, 11'h010, 11'h011,
        11'h00e, 11'h7ff};
    logic [7:0]  et [8] = '{8'h1e, 8'h77, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
    spi_register_command_decoder dut_u (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .clk_en_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo),
        .power_down_control_out(pd), .input_mode_out(mode),
        .output_protocol_select_out(proto), .output_rate_select_out(rate),
        .status_pin_config_out(stat), .output_word_config_out(word),
        .parity_config_out(par), .write_unlocked_out(unl));
    spi_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));
    initial forever #4 sys_clk_in = ~sys_clk_in;
    // verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one full-length frame
    task automatic cmd(input logic [4:0] op, input logic [10:0] a, input logic [7:0] d);
        host_u.frame({op, a, d}, 24, rd);
    endtask
    // read frame, then a no-op frame carrying the byte out and zeros after it
    task automatic rdc(input logic [10:0] a, input logic [7:0] e);
        cmd(`OP_READ, a, 8'h00);
        cmd(`OP_NOP, 11'h000, 8'h00);
        `CHK(rd, {e, 16'h0000})
    endtask
    // about seventy-five frames of 3.3 us are due; a stuck frame ends the run here
    initial
    begin
        #500000;
        error_cnt++;
        summarize();
    end
    // main sequence
    initial
    begin
        repeat (8) @(posedge sys_clk_in);
        #1 nrst_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        `CHK({unl, pd}, 9'h000)
        rdc(`ADDR_UNLOCK, 8'h00);
        cmd(`OP_WRITE, `ADDR_OUT_RATE, 8'h5a);
        `CHK(rate, 8'h00)
        cmd(`OP_WRITE, `ADDR_UNLOCK, 8'hab);
        `CHK(unl, 1'b0)
        cmd(`OP_WRITE, `ADDR_UNLOCK, `UNLOCK_KEY);
        `CHK(unl, 1'b1)
        rdc(`ADDR_UNLOCK, 8'haa);
        for (int i = 0; i < 8; i++)
        begin
            cmd(`OP_WRITE, at[i], 8'hff);
            rdc(at[i], et[i]);
        end
        `CHK({pd, proto, stat, word, par, mode}, 42'h079dffffffc)
        cmd(`OP_WRITE, `ADDR_IN_PROTO, 8'hfc);
        `CHK(mode, 2'h0)
        rdc(`ADDR_IN_PROTO, 8'h00);
        cmd(`OP_WRITE, `ADDR_OUT_RATE, 8'h5a);
        cmd(`OP_SET_BITS, `ADDR_OUT_RATE, 8'h81);
        `CHK(rate, 8'hdb)
        cmd(`OP_CLEAR_BITS, `ADDR_OUT_RATE, 8'h1b);
        `CHK(rate, 8'hc0)
        // no-op and every reserved code; none may start a read either
        for (int op = 0; op < 32; op++)
        begin
            if (op == 0 || op > 4)
            begin
                cmd(op[4:0], `ADDR_OUT_RATE, 8'hff);
                `CHK({rate, rd}, 32'hc0000000)
            end
        end
        host_u.frame({`OP_WRITE, `ADDR_OUT_RATE, 8'h33}, 23, rd);
        `CHK(rate, 8'hc0)
        host_u.frame({`OP_WRITE, `ADDR_OUT_RATE, 8'h33}, 25, rd);
        `CHK(rate, 8'hc0)
        cmd(`OP_READ, `ADDR_POWER_DOWN, 8'h00);
        cmd(`OP_READ, `ADDR_OUT_RATE, 8'h00);
        `CHK(rd, 24'h1e0000)
        cmd(`OP_WRITE, `ADDR_OUT_RATE, 8'h11);
        `CHK({rd, rate}, 32'hc0000011)
        cmd(`OP_WRITE, `ADDR_UNLOCK, 8'h55);
        cmd(`OP_WRITE, `ADDR_OUT_RATE, 8'h77);
        `CHK({unl, rate}, 9'h011)
        cmd(`OP_SET_BITS, `ADDR_UNLOCK, 8'haa);
        cmd(`OP_CLEAR_BITS, `ADDR_UNLOCK, 8'h55);
        `CHK(unl, 1'b1)
        @(posedge sys_clk_in);
        #1 nrst_in = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1 nrst_in = 1'b1;
        `CHK({unl, rate}, 9'h000)
        summarize();
    end
endmodule // test_spi_register_command_decoder
bind spi_register_command_decoder spi_cmd_checker chk_u (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .sdo_out(sdo_out),
    .power_down_control_out(power_down_control_out), .input_mode_out(input_mode_out),
    .output_protocol_select_out(output_protocol_select_out),
    .output_rate_select_out(output_rate_select_out),
    .status_pin_config_out(status_pin_config_out),
    .output_word_config_out(output_word_config_out),
    .parity_config_out(parity_config_out), .write_unlocked_out(write_unlocked_out));
`default_nettype wire
